/* File: design/port_b_pin_function_logic.sv */
// Port B pin logic: direction, pull-up, input enable, wake, edge interrupt
// and alternate timer/PWM outputs. Assumes the pad turns pin_oe into drive
// and pull_en into a weak pull-up; all control comes in as plain ports.
`timescale 1ns/10ps
`include "port_b_map.svh"
// Functional notes
// RULE1 - [RULE1] Each bit is input or push-pull output, each with own pull-up.
// RULE2 - [RULE2] Input-enable bit n gates pin n's digital input buffer.
// RULE3 - [RULE3] Software clears input-enable on pins used as analog inputs.
// RULE4 - [RULE4] Any pin may wake; wake is off while its input-enable is 0.
// RULE5 - [RULE5] Pin 0 is interrupt line one, requesting on both edges.
// RULE6 - [RULE6] Timer three output selectable onto pins 5 and 6.
// RULE7 - [RULE7] Timer two output selectable onto pins 4 and 2.
// RULE8 - [RULE8] PWM 0 to pins 5,4; PWM 1 to pin 6; PWM 2 to 3,2.
// RULE9 - [RULE9] An enabled alternate output replaces the port data bit.
module port_b_pin_function_logic (
  input wire logic clock,
  input wire logic rst,
  input wire port_b_pkg::pin_vec_t pin_in,
  input wire port_b_pkg::pin_vec_t port_data,
  input wire port_b_pkg::pin_vec_t port_dir,
  input wire port_b_pkg::pin_vec_t pull_up_sel,
  input wire port_b_pkg::pin_vec_t input_enable,
  input wire port_b_pkg::pin_vec_t wake_enable,
  input wire logic sleeping,
  input wire logic int_line_enable,
  input wire logic timer_two_pwm_out,
  input wire logic timer_three_pwm_out,
  input wire logic wide_pwm_zero_out,
  input wire logic wide_pwm_one_out,
  input wire logic wide_pwm_two_out,
  input wire logic t3_on_pin5,
  input wire logic t3_on_pin6,
  input wire logic t2_on_pin4,
  input wire logic t2_on_pin2,
  input wire logic g0_on_pin5,
  input wire logic g0_on_pin4,
  input wire logic g1_on_pin6,
  input wire logic g2_on_pin3,
  input wire logic g2_on_pin2,
  output port_b_pkg::pin_vec_t pin_out,
  output port_b_pkg::pin_vec_t pin_oe,
  output port_b_pkg::pin_vec_t pull_en,
  output port_b_pkg::pin_vec_t port_read,
  output logic wake_request,
  output logic external_interrupt_line_one
);
  import port_b_pkg::*;

  pin_vec_t pin_sync_w;
  pin_vec_t gated_w;
  pin_vec_t drive_w;
  pin_vec_t alt_en_w;
  logic int_prev_reg;
  pin_vec_t wake_ref_reg;
  logic [1:0] arm_reg;
  logic armed_w;

  // Pads are asynchronous, so every input sees two flops first
  pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync_w)
  );

  // Choose the source for one pin; later alternates take precedence
  function automatic logic pick(input logic gpio, input logic en_a,
                                input logic sig_a, input logic en_b,
                                input logic sig_b);
    logic r;
    r = gpio;
    if (en_a) begin
      r = sig_a;
    end
    if (en_b) begin
      r = sig_b;
    end
    return r;
  endfunction : pick

  // Alternate output muxing onto the selected pins
  always_comb begin
    drive_w = port_data;
    alt_en_w = 8'h00;
    drive_w[`PB_T3_PIN_B] = pick(port_data[`PB_T3_PIN_B], t3_on_pin6,
      timer_three_pwm_out, g1_on_pin6, wide_pwm_one_out); // [RULE6] [RULE8]
    drive_w[`PB_T3_PIN_A] = pick(port_data[`PB_T3_PIN_A], t3_on_pin5,
      timer_three_pwm_out, g0_on_pin5, wide_pwm_zero_out); // [RULE6] [RULE8]
    drive_w[`PB_T2_PIN_A] = pick(port_data[`PB_T2_PIN_A], t2_on_pin4,
      timer_two_pwm_out, g0_on_pin4, wide_pwm_zero_out); // [RULE7] [RULE8]
    drive_w[`PB_G2_PIN_A] = pick(port_data[`PB_G2_PIN_A], 1'b0, 1'b0,
      g2_on_pin3, wide_pwm_two_out); // [RULE8]
    drive_w[`PB_T2_PIN_B] = pick(port_data[`PB_T2_PIN_B], t2_on_pin2,
      timer_two_pwm_out, g2_on_pin2, wide_pwm_two_out); // [RULE7] [RULE8]
    alt_en_w[`PB_T3_PIN_B] = t3_on_pin6 | g1_on_pin6;
    alt_en_w[`PB_T3_PIN_A] = t3_on_pin5 | g0_on_pin5;
    alt_en_w[`PB_T2_PIN_A] = t2_on_pin4 | g0_on_pin4;
    alt_en_w[`PB_G2_PIN_A] = g2_on_pin3;
    alt_en_w[`PB_T2_PIN_B] = t2_on_pin2 | g2_on_pin2;
  end

  // Input buffer gating; a disabled buffer reads as 0, and an analog pin
  // left enabled would leak, which software must avoid [RULE3]
  assign gated_w = pin_sync_w & input_enable; // [RULE2]

  // Edge and wake compares wait until the synchroniser holds real pad
  // levels, so a pin idling high gives no false interrupt after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      arm_reg <= 2'h0;
    end else if (arm_reg != `PB_ARM_CYCLES) begin
      arm_reg <= arm_reg + 2'h1;
    end
  end
  assign armed_w = (arm_reg == `PB_ARM_CYCLES);

  // Pad controls are registered so outputs come from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= `PB_DATA_RST;
      pin_oe <= `PB_DIR_RST;
      pull_en <= `PB_PULL_RST;
    end else begin
      pin_out <= drive_w; // [RULE9]
      pin_oe <= port_dir | alt_en_w; // [RULE1] [RULE9]
      pull_en <= pull_up_sel & ~(port_dir | alt_en_w); // [RULE1]
    end
  end

  // Readback of the gated input path
  always_ff @(posedge clock) begin
    if (rst) begin
      port_read <= 8'h00;
    end else begin
      port_read <= gated_w; // [RULE2]
    end
  end

  // Both-edge detect on pin 0, one-cycle request pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      int_prev_reg <= 1'b0;
      external_interrupt_line_one <= 1'b0;
    end else begin
      int_prev_reg <= gated_w[`PB_INT_PIN];
      external_interrupt_line_one <= int_line_enable & armed_w &
        (gated_w[`PB_INT_PIN] ^ int_prev_reg); // [RULE5]
    end
  end

  // Wake on any change versus the level seen when awake; masked by the
  // input enable so a floating analog pin cannot wake the part
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_ref_reg <= 8'h00;
      wake_request <= 1'b0;
    end else begin
      if (!sleeping) begin
        wake_ref_reg <= gated_w;
      end
      wake_request <= sleeping & armed_w & |((gated_w ^ wake_ref_reg)
        & wake_enable & input_enable); // [RULE4]
    end
  end

  property p_int_edge;
    @(posedge clock) disable iff (rst)
      (int_line_enable && armed_w && $changed(gated_w[`PB_INT_PIN]))
      |=> external_interrupt_line_one;
  endproperty
  a_int_edge: assert property (p_int_edge) // [RULE5]
    else $error("edge on pin 0 gave no interrupt");

  property p_int_quiet;
    @(posedge clock) disable iff (rst)
      $stable(gated_w[`PB_INT_PIN]) |=> !external_interrupt_line_one;
  endproperty
  a_int_quiet: assert property (p_int_quiet) // [RULE5]
    else $error("interrupt without edge");

  property p_int_off;
    @(posedge clock) disable iff (rst)
      !int_line_enable |=> !external_interrupt_line_one;
  endproperty
  a_int_off: assert property (p_int_off) // [RULE5]
    else $error("interrupt while line disabled");

  property p_die_gate;
    @(posedge clock) disable iff (rst)
      !input_enable[1] |=> !port_read[1];
  endproperty
  a_die_gate: assert property (p_die_gate) // [RULE2]
    else $error("disabled input buffer read high");

  property p_wake_mask;
    @(posedge clock) disable iff (rst)
      (input_enable == 8'h00) |=> !wake_request;
  endproperty
  a_wake_mask: assert property (p_wake_mask) // [RULE4]
    else $error("wake from disabled input");

  property p_dir_out;
    @(posedge clock) disable iff (rst)
      port_dir[1] |=> (pin_oe[1] && pin_out[1] == $past(port_data[1]));
  endproperty
  a_dir_out: assert property (p_dir_out) // [RULE1]
    else $error("output pin not driving its data");

  property p_t3_pin6;
    @(posedge clock) disable iff (rst)
      (t3_on_pin6 && !g1_on_pin6)
      |=> (pin_out[6] == $past(timer_three_pwm_out) && pin_oe[6]);
  endproperty
  a_t3_pin6: assert property (p_t3_pin6) // [RULE6]
    else $error("timer three missing on pin 6");

  property p_t2_pin4;
    @(posedge clock) disable iff (rst)
      (t2_on_pin4 && !g0_on_pin4)
      |=> pin_out[4] == $past(timer_two_pwm_out);
  endproperty
  a_t2_pin4: assert property (p_t2_pin4) // [RULE7]
    else $error("timer two missing on pin 4");

  property p_g2_pin3;
    @(posedge clock) disable iff (rst)
      g2_on_pin3 |=> (pin_out[3] == $past(wide_pwm_two_out) && pin_oe[3]);
  endproperty
  a_g2_pin3: assert property (p_g2_pin3) // [RULE8] [RULE9]
    else $error("pwm two missing on pin 3");

  c_int: cover property (@(posedge clock) external_interrupt_line_one);
  c_wake: cover property (@(posedge clock) wake_request);
  c_alt: cover property (@(posedge clock) g0_on_pin5 && pin_oe[5]);
  c_int_off: cover property (@(posedge clock) !int_line_enable &&
    $changed(gated_w[`PB_INT_PIN]));
  c_wake_masked: cover property (@(posedge clock) sleeping &&
    (input_enable == 8'h00));
endmodule : port_b_pin_function_logic

/* File: design/port_b_map.svh */
// Constants for the port B pin function logic: reset values, pin indices.
// Assumes inclusion by the package and the modules of this block only.
`ifndef PORT_B_MAP_SVH
`define PORT_B_MAP_SVH
`define PB_WIDTH 8
`define PB_DATA_RST 8'h00
`define PB_DIR_RST 8'h00
`define PB_PULL_RST 8'h00
`define PB_DIE_RST 8'hFF
`define PB_WAKE_RST 8'h00
`define PB_INT_PIN 0
`define PB_T3_PIN_A 5
`define PB_T3_PIN_B 6
`define PB_T2_PIN_A 4
`define PB_T2_PIN_B 2
`define PB_G0_PIN_A 5
`define PB_G0_PIN_B 4
`define PB_G1_PIN 6
`define PB_G2_PIN_A 3
`define PB_G2_PIN_B 2
`define EDGE_MODE_BOTH 2'h3
`define PB_ARM_CYCLES 2'h3
`endif

/* File: design/port_b_pkg.sv */
// Types for the port B pin function logic.
// Assumes the constants header sits beside it.
`include "port_b_map.svh"
package port_b_pkg;
  typedef logic [`PB_WIDTH-1:0] pin_vec_t;
  // Alternate source choice per pin
  typedef enum logic [2:0] {
    SRC_GPIO = 3'h0,
    SRC_T2 = 3'h1,
    SRC_T3 = 3'h2,
    SRC_G0 = 3'h3,
    SRC_G1 = 3'h4,
    SRC_G2 = 3'h5
  } alt_src_e;
endpackage : port_b_pkg

/* File: design/pin_sync.sv */
// Two-flop synchroniser for the eight pad inputs.
// Assumes pins are asynchronous to clock.
`timescale 1ns/10ps
module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta_reg;
  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

/* File: verif/board_pins.sv */
// Board model for the eight port B pads: drives, pulls up or floats each.
// Assumes the bench chooses which pads the board drives and to what level.
`timescale 1ns/10ps
module board_pins (
  input wire logic clock,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] board_val,
  input wire logic [7:0] board_en,
  output logic [7:0] pin_in
);
  logic [7:0] last_reg;
  // Pad level; a floating pad toggles so it is never mistaken for a level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (board_en[i]) pin_in[i] = board_val[i];
      else if (pull_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = (last_reg[i] !== 1'b1);
    end
  end
  // Remembers the last level to invert it while floating
  always_ff @(posedge clock) last_reg <= pin_in;
endmodule : board_pins

/* File: verif/port_b_pin_function_logic_tb_top.sv */
// Self-checking bench for the port B pin function logic.
// Assumes the board model and the design files are compiled first.
`timescale 1ns/10ps
module port_b_pin_function_logic_tb_top;
  logic clock, rst, sleeping, int_line_enable, wake_request, irq;
  logic [7:0] pin_in, port_data, port_dir, pull_up_sel, input_enable;
  logic [7:0] wake_enable, pin_out, pin_oe, pull_en, port_read;
  logic [7:0] board_val, board_en;
  logic [4:0] src;
  logic [8:0] sel;
  int n_fail = 0, total_checks = 0, n_irq = 0;
  // Pin and source of each select, in select order
  localparam int alt_pin [9] = '{5, 6, 4, 2, 5, 4, 6, 3, 2};
  localparam int alt_src [9] = '{1, 1, 0, 0, 2, 2, 3, 4, 4};
  port_b_pin_function_logic uut (.clock(clock), .rst(rst),
    .pin_in(pin_in), .port_data(port_data), .port_dir(port_dir),
    .pull_up_sel(pull_up_sel), .input_enable(input_enable),
    .wake_enable(wake_enable), .sleeping(sleeping),
    .int_line_enable(int_line_enable), .timer_two_pwm_out(src[0]),
    .timer_three_pwm_out(src[1]), .wide_pwm_zero_out(src[2]),
    .wide_pwm_one_out(src[3]), .wide_pwm_two_out(src[4]),
    .t3_on_pin5(sel[0]), .t3_on_pin6(sel[1]), .t2_on_pin4(sel[2]),
    .t2_on_pin2(sel[3]), .g0_on_pin5(sel[4]), .g0_on_pin4(sel[5]),
    .g1_on_pin6(sel[6]), .g2_on_pin3(sel[7]), .g2_on_pin2(sel[8]),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .port_read(port_read), .wake_request(wake_request),
    .external_interrupt_line_one(irq));
  board_pins board (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .board_val(board_val), .board_en(board_en),
    .pin_in(pin_in));
  // Free-running clock and interrupt pulse counter
  always #4 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) n_irq++;
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task test_dir_pull;
    port_dir = 8'h0F; port_data = 8'hA5; pull_up_sel = 8'hFF;
    tick(5);
    check("pin_oe", 8'h0F, pin_oe);
    check("pin_out", 8'h05, pin_out & 8'h0F);
    check("pull_en", 8'hF0, pull_en);
    check("port_read", 8'hF5, port_read);
    $display("test_dir_pull done");
  endtask : test_dir_pull
  task test_input_enable;
    port_dir = 8'h00; pull_up_sel = 8'h00; board_en = 8'hFF;
    board_val = 8'h5A; input_enable = 8'hF0; // Low pins analog
    tick(5);
    check("port_read", 8'h50, port_read);
    $display("test_input_enable done");
  endtask : test_input_enable
  task test_irq;
    input_enable = 8'hFF; board_val = 8'h00; tick(5);
    n_irq = 0; board_val[0] = 1'b1; tick(6);
    board_val[0] = 1'b0; tick(6);
    check("irq_count", 8'd2, 8'(n_irq));
    input_enable[0] = 1'b0; board_val[0] = 1'b1; tick(6);
    check("irq_gated", 8'd2, 8'(n_irq));
    int_line_enable = 1'b0; input_enable[0] = 1'b1; tick(6);
    board_val[0] = 1'b0; tick(6);
    check("irq_off", 8'd2, 8'(n_irq));
    int_line_enable = 1'b1; tick(1);
    $display("test_irq done");
  endtask : test_irq
  task test_wake;
    int k;
    input_enable = 8'hFE; board_val = 8'h00; tick(5);
    sleeping = 1'b1; tick(3); board_val[0] = 1'b1; tick(6);
    check("wake_gated", 8'h00, {7'h0, wake_request});
    board_val[1] = 1'b1;
    for (k = 0; k < 8 && wake_request !== 1'b1; k++) tick(1);
    if (k == 8) begin
      n_fail++; $display("MISMATCH wake_request expected 1 seen timeout");
      complete_run();
    end
    check("wake", 8'h01, {7'h0, wake_request});
    input_enable = 8'h00; tick(2);
    check("wake_masked", 8'h00, {7'h0, wake_request});
    input_enable = 8'hFE;
    sleeping = 1'b0; tick(3);
    $display("test_wake done");
  endtask : test_wake
  task test_alt;
    for (int i = 0; i < 9; i++) begin
      port_data = 8'h00; sel = 9'h1 << i; src = 5'h01 << alt_src[i];
      tick(2);
      check("alt_oe", 8'h1 << alt_pin[i], pin_oe);
      check("alt_out", 8'h1 << alt_pin[i], pin_out);
      port_data = 8'hFF; src = ~(5'h01 << alt_src[i]); tick(2);
      check("alt_low", 8'h00, pin_out & (8'h1 << alt_pin[i]));
    end
    sel = 9'h000;
    $display("test_alt done");
  endtask : test_alt
  // Main sequence: reset, then each scenario in turn
  initial begin
    clock = 0; rst = 1; sleeping = 0; int_line_enable = 1; src = 5'h00;
    sel = 9'h000; port_data = 8'h00; port_dir = 8'h00; pull_up_sel = 8'h00;
    input_enable = 8'hFF; wake_enable = 8'hFF; board_val = 8'h00;
    board_en = 8'h00;
    tick(20);
    check("reset_oe", 8'h00, pin_oe);
    check("reset_pull", 8'h00, pull_en);
    check("reset_read", 8'h00, port_read);
    check("reset_out", 8'h00, pin_out);
    check("reset_req", 8'h00, {6'h0, wake_request, irq});
    rst = 0;
    test_dir_pull();
    test_input_enable();
    test_irq();
    test_wake();
    test_alt();
    complete_run();
  end
endmodule : port_b_pin_function_logic_tb_top
